// ### adc_model.sv
// converter model: one sample strobe every four cycles
`timescale 1ns/1ps
module adc_model (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [11:0] code,
    output logic valid,
    output logic [11:0] sample
);
    // ===
    // sampling
    logic [1:0] cnt_q;
    // off-strobe bus is garbage: a late latch shows
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q <= 2'h0;
            valid <= 1'b0;
            sample <= 12'h000;
        end else begin
            cnt_q <= cnt_q + 2'h1;
            valid <= (cnt_q == 2'h0);
            sample <= (cnt_q == 2'h0) ? code : ~sample;
        end
    end
endmodule

// ### ain_cond.sv
// three-channel analog input conditioning and function routing
//
// Summary of operation
// R1 - function code 0 routes to speed reference, 3 user program, 4 thermistor, 5/6 main PID feedbacks, 8 external PID feedback, others nowhere.
// R2 - a speed-reference input is clamped to min and max speed and then ramped.
// R3 - a user-program input is exposed only to the user-program area.
// R4 - the thermistor function needs an analog output set up as current source, outside this block.
// R5 - thermistor code on the third input forces the configuration fault state.
// R6 - main PID feedback 1 and 2 feed the main controller, combined per the feedback mode.
// R7 - for codes 5 to 8 a lower-numbered input wins over a higher one.
// R8 - each sample goes normalise, offset, gain, filter, then routing.
// R9 - signal types 0 to 3 are legal everywhere, type 4 (bipolar) only on input three.
// R10 - types 2 and 3 give 100 percent minus the offset-and-gain result.
// R11 - percent is reading over full scale times 100 plus offset times gain; 4-20 mA drops 4 mA over a 16 mA span.
// R12 - a negative speed value commands reverse at that percent of max speed.
// R13 - the filter setting, 0 to 16.00 s, is a low-pass time constant.
// R14 - the filter settles in about three time constants.
// R15 - each channel value is readable as a percent after offset and gain.
// R16 - gain 0.000 to 9.999, offset -100.0 to 100.0 percent, results saturate at 100 percent.
// R17 - the filter is a discrete first-order lag at a fixed period, coefficient from the time constant.
`timescale 1ns/1ps
module ain_cond #(
    parameter int unsigned TICK_CYCLES = ain_pkg::TICK_CYCLES_DEF
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [7:0] addr,
    input wire logic [31:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [31:0] rd_data,
    input wire logic in1_valid,
    input wire logic [ain_pkg::SAMPLE_W-1:0] in1_sample,
    input wire logic in2_valid,
    input wire logic [ain_pkg::SAMPLE_W-1:0] in2_sample,
    input wire logic in3_valid,
    input wire logic [ain_pkg::SAMPLE_W-1:0] in3_sample,
    output logic signed [15:0] speed_ref_rpm,
    output logic speed_reverse,
    output logic [2:0] user_prog_valid,
    output logic signed [15:0] user_prog1_value,
    output logic signed [15:0] user_prog2_value,
    output logic signed [15:0] user_prog3_value,
    output logic therm_valid,
    output logic signed [15:0] therm_value,
    output logic pid_fb1_valid,
    output logic signed [15:0] pid_fb1_value,
    output logic pid_fb2_valid,
    output logic signed [15:0] pid_fb2_value,
    output logic pid_ext_valid,
    output logic signed [15:0] pid_ext_value,
    output logic [1:0] pid_feedback_mode,
    output logic config_fault_state
);
    import ain_pkg::*;

    typedef struct packed {
        logic [2:0][3:0] func_sel;
        logic [2:0][2:0] signal_type;
        logic [2:0][13:0] gain;
        logic [2:0][15:0] offset;
        logic [2:0][10:0] filter_tc;
        logic [1:0] local_ref_source_sel;
        logic [1:0] remote_ref_source_sel;
        logic remote_active;
        logic [15:0] min_speed_limit;
        logic [15:0] max_speed_limit;
        logic [15:0] ramp_acc;
        logic [15:0] ramp_dec;
        logic [1:0] pid_mode;
        logic [31:0] rd_data;
        logic [16:0] tick_cnt;
        logic tick;
        logic signed [15:0] target;
        logic reverse;
        logic [2:0] user_v;
        logic [2:0][15:0] user_val;
        logic therm_v;
        logic [15:0] therm_val;
        logic [2:0] pid_v;
        logic [2:0][15:0] pid_val;
        logic fault;
    } top_state_t;

    top_state_t q, n;

    logic [2:0] ch_valid;
    logic [2:0][SAMPLE_W-1:0] ch_sample;
    logic [2:0][15:0] cond_val;
    logic [2:0][15:0] filt_val;
    logic [2:0] type_bad;
    logic signed [15:0] ramp_speed;

    assign ch_valid = {in3_valid, in2_valid, in1_valid};
    assign ch_sample = {in3_sample, in2_sample, in1_sample};

    // ===
    // channel conditioning
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_ch
            chan_cond #(
                .BIPOLAR_OK(gi == 2)
            ) u_chan (
                .clk(clk),
                .reset_n(reset_n),
                .sample_valid(ch_valid[gi]),
                .sample(ch_sample[gi]),
                .signal_type(q.signal_type[gi]),
                .offset(q.offset[gi]),
                .gain(q.gain[gi]),
                .filter_tc(q.filter_tc[gi]),
                .tick(q.tick),
                .cond_value(cond_val[gi]),
                .filt_value(filt_val[gi]),
                .type_bad(type_bad[gi])
            );
        end
    endgenerate

    speed_ramp u_ramp (
        .clk(clk),
        .reset_n(reset_n),
        .tick(q.tick),
        .target(q.target),
        .acc_step(q.ramp_acc),
        .dec_step(q.ramp_dec),
        .speed(ramp_speed)
    );

    // ===
    // routing helpers
    // returns one plus the index of the first input holding the code
    function automatic logic [1:0] pick(
        input logic [2:0][3:0] f,
        input logic [2:0] allow,
        input logic [3:0] code
    );
        logic [1:0] r;
        r = 2'h0;
        for (int i = 2; i >= 0; i--) begin
            if (allow[i] && f[i] == code) begin
                r = 2'(i + 1); // [R7]
            end
        end
        return r;
    endfunction

    function automatic int sat(input int v, input int lo, input int hi);
        return (v > hi) ? hi : ((v < lo) ? lo : v);
    endfunction

    // ===
    // next state
    always_comb begin
        logic [1:0] ch;
        logic [4:0] fld;
        logic chan_hit;
        logic [1:0] src;
        logic [1:0] sel;
        logic [2:0] ok;
        int mag;
        int v;
        ch = 2'(addr[6:5] - 2'h1);
        fld = addr[4:0];
        chan_hit = !addr[7] && addr[6:5] != 2'h0;
        src = 2'h0;
        sel = 2'h0;
        ok = 3'h0;
        mag = 0;
        v = 0;
        n = q;

        // tick divider sets the filter and ramp period
        if (32'(q.tick_cnt) >= TICK_CYCLES - 1) begin
            n.tick_cnt = '0;
            n.tick = 1'b1;
        end else begin
            n.tick_cnt = q.tick_cnt + 17'h00001;
            n.tick = 1'b0;
        end

        // register writes, limits saturate on the way in
        if (wr_en) begin
            if (chan_hit) begin
                case (fld)
                    CH_FUNC: n.func_sel[ch] = wr_data[3:0];
                    CH_TYPE: n.signal_type[ch] = wr_data[2:0];
                    CH_GAIN: n.gain[ch] =
                        14'(sat(int'(wr_data[15:0]), 0, GAIN_MAX)); // [R16]
                    CH_OFFSET: n.offset[ch] = 16'(sat(
                        int'($signed(wr_data[15:0])), -PCT_MAX, PCT_MAX)); // [R16]
                    CH_FILT: n.filter_tc[ch] =
                        11'(sat(int'(wr_data[15:0]), 0, TC_MAX)); // [R13]
                    default: ;
                endcase
            end else begin
                case (addr)
                    REG_REF_SEL: begin
                        n.local_ref_source_sel = wr_data[1:0];
                        n.remote_ref_source_sel = wr_data[3:2];
                        n.remote_active = wr_data[4];
                    end
                    REG_MIN_SPEED: n.min_speed_limit = wr_data[15:0];
                    REG_MAX_SPEED: n.max_speed_limit = wr_data[15:0];
                    REG_RAMP_ACC: n.ramp_acc = wr_data[15:0];
                    REG_RAMP_DEC: n.ramp_dec = wr_data[15:0];
                    REG_PID_MODE: n.pid_mode = wr_data[1:0];
                    default: ;
                endcase
            end
        end

        // register reads, data stand one cycle later
        n.rd_data = '0;
        if (rd_en) begin
            if (chan_hit) begin
                case (fld)
                    CH_FUNC: n.rd_data = 32'(q.func_sel[ch]);
                    CH_TYPE: n.rd_data = 32'(q.signal_type[ch]);
                    CH_GAIN: n.rd_data = 32'(q.gain[ch]);
                    CH_OFFSET: n.rd_data = 32'($signed(q.offset[ch]));
                    CH_FILT: n.rd_data = 32'(q.filter_tc[ch]);
                    CH_VALUE: n.rd_data = 32'($signed(cond_val[ch])); // [R15]
                    default: n.rd_data = '0;
                endcase
            end else begin
                case (addr)
                    REG_REF_SEL: n.rd_data = {27'h0, q.remote_active,
                        q.remote_ref_source_sel, q.local_ref_source_sel};
                    REG_MIN_SPEED: n.rd_data = 32'(q.min_speed_limit);
                    REG_MAX_SPEED: n.rd_data = 32'(q.max_speed_limit);
                    REG_RAMP_ACC: n.rd_data = 32'(q.ramp_acc);
                    REG_RAMP_DEC: n.rd_data = 32'(q.ramp_dec);
                    REG_PID_MODE: n.rd_data = 32'(q.pid_mode);
                    REG_STATUS: n.rd_data = {14'h0, q.reverse, q.fault,
                        ramp_speed};
                    default: n.rd_data = '0;
                endcase
            end
        end

        // configuration fault: bipolar input cannot read a thermistor
        n.fault = (q.func_sel[2] == FN_THERM) || (|type_bad); // [R5] [R9]
        ok = n.fault ? 3'h0 : 3'h7;

        // user program area sees each input on its own
        for (int i = 0; i < 3; i++) begin
            n.user_v[i] = ok[i] && q.func_sel[i] == FN_USER; // [R3]
            n.user_val[i] = n.user_v[i] ? filt_val[i] : '0; // [R3]
        end

        // thermistor only on the two unipolar inputs
        sel = pick(q.func_sel, {1'b0, ok[1:0]}, FN_THERM); // [R1]
        n.therm_v = sel != 2'h0;
        n.therm_val = n.therm_v ? filt_val[2'(sel - 2'h1)] : '0;

        // PID feedbacks, lowest input number wins on duplicates
        for (int k = 0; k < 3; k++) begin
            case (k)
                0: sel = pick(q.func_sel, ok, FN_PID1); // [R6] [R7]
                1: sel = pick(q.func_sel, ok, FN_PID2); // [R6] [R7]
                default: sel = pick(q.func_sel, ok, FN_EXT); // [R1] [R7]
            endcase
            n.pid_v[k] = sel != 2'h0;
            n.pid_val[k] = n.pid_v[k] ? filt_val[2'(sel - 2'h1)] : '0;
        end

        // speed reference from the selected source input
        src = q.remote_active ? q.remote_ref_source_sel
                              : q.local_ref_source_sel;
        n.target = '0;
        n.reverse = 1'b0;
        if (src != 2'h0 && ok[2'(src - 2'h1)]
                && q.func_sel[2'(src - 2'h1)] == FN_SPEED) begin // [R1]
            v = int'($signed(filt_val[2'(src - 2'h1)]));
            mag = int'((longint'((v < 0) ? -v : v)
                * longint'(q.max_speed_limit) * DIV1000_MUL)
                >>> DIV1000_SH); // [R12]
            mag = sat(mag, int'(q.min_speed_limit),
                int'(q.max_speed_limit)); // [R2]
            n.reverse = v < 0; // [R12]
            n.target = 16'(n.reverse ? -mag : mag); // [R12]
        end
    end

    // ===
    // state register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            q <= '{func_sel: RST_FUNC, signal_type: '0,
                   gain: {RST_GAIN, RST_GAIN, RST_GAIN}, offset: '0,
                   filter_tc: '0, local_ref_source_sel: '0,
                   remote_ref_source_sel: '0, remote_active: 1'b0,
                   min_speed_limit: RST_MIN_SPEED,
                   max_speed_limit: RST_MAX_SPEED,
                   ramp_acc: RST_RAMP_STEP, ramp_dec: RST_RAMP_STEP,
                   pid_mode: '0, rd_data: '0, tick_cnt: '0, tick: 1'b0,
                   target: '0, reverse: 1'b0, user_v: '0, user_val: '0,
                   therm_v: 1'b0, therm_val: '0, pid_v: '0, pid_val: '0,
                   fault: 1'b0};
        end else begin
            q <= n;
        end
    end

    // ===
    // outputs
    assign rd_data = q.rd_data;
    assign speed_ref_rpm = ramp_speed;
    assign speed_reverse = q.reverse;
    assign user_prog_valid = q.user_v;
    assign user_prog1_value = q.user_val[0];
    assign user_prog2_value = q.user_val[1];
    assign user_prog3_value = q.user_val[2];
    assign therm_valid = q.therm_v;
    assign therm_value = q.therm_val;
    assign pid_fb1_valid = q.pid_v[0];
    assign pid_fb1_value = q.pid_val[0];
    assign pid_fb2_valid = q.pid_v[1];
    assign pid_fb2_value = q.pid_val[1];
    assign pid_ext_valid = q.pid_v[2];
    assign pid_ext_value = q.pid_val[2];
    assign pid_feedback_mode = q.pid_mode; // [R6]
    assign config_fault_state = q.fault;
endmodule

// ### ain_cond_asserts.sv
// port checker for the analog input conditioning block
`timescale 1ns/1ps
module ain_cond_asserts
    import ain_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [7:0] addr,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [31:0] rd_data,
    input wire logic speed_reverse,
    input wire logic [2:0] user_prog_valid,
    input wire logic signed [15:0] user_prog1_value,
    input wire logic signed [15:0] user_prog2_value,
    input wire logic signed [15:0] user_prog3_value,
    input wire logic therm_valid,
    input wire logic pid_fb1_valid,
    input wire logic signed [15:0] pid_fb1_value,
    input wire logic pid_fb2_valid,
    input wire logic signed [15:0] pid_fb2_value,
    input wire logic pid_ext_valid,
    input wire logic signed [15:0] pid_ext_value,
    input wire logic [1:0] pid_feedback_mode,
    input wire logic config_fault_state
);
    // ===
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_read;
        rd_en ##1 !rd_en;
    endsequence
    sequence s_fault;
        config_fault_state [*2];
    endsequence
    a_rd_idle: assert property (rd_data != 0 |-> $past(rd_en))
        else $error("read data outside read slot");
    a_rd_once: assert property (s_read |-> ##1 rd_data == 0)
        else $error("read data held too long");
    a_user_zero: assert property ((user_prog_valid[0] || user_prog1_value == 0)
        && (user_prog_valid[1] || user_prog2_value == 0)
        && (user_prog_valid[2] || user_prog3_value == 0))
        else $error("user value without route");
    a_pid_range: assert property (pid_fb1_value <= 1000
        && pid_fb1_value >= -1000 && pid_fb2_value <= 1000
        && pid_fb2_value >= -1000 && pid_ext_value <= 1000
        && pid_ext_value >= -1000) else $error("pid value out of range");
    a_user_range: assert property (user_prog1_value <= 1000
        && user_prog1_value >= -1000) else $error("user value out of range");
    a_fault_route: assert property (s_fault |-> user_prog_valid == 0
        && !therm_valid && !pid_fb1_valid && !pid_fb2_valid
        && !pid_ext_valid) else $error("route live during fault");
    a_fault_speed: assert property (s_fault |-> !speed_reverse)
        else $error("reverse during fault");
    a_mode_write: assert property ($changed(pid_feedback_mode) |->
        $past(wr_en && addr == REG_PID_MODE)
        || $past(wr_en && addr == REG_PID_MODE, 2))
        else $error("feedback mode changed without write");
endmodule
bind ain_cond ain_cond_asserts chk (.*);

// ### ain_cond_tb.sv
// self-checking bench for the analog input conditioning block
`timescale 1ns/1ps
module ain_cond_tb;
    import ain_pkg::*;
    logic clk = 0, reset_n = 0, wr_en = 0, rd_en = 0;
    logic [7:0] addr = 0;
    logic [31:0] wr_data = 0, rd_data;
    logic [11:0] c1 = 0, c2 = 0, c3 = 0, in1_sample, in2_sample, in3_sample;
    logic in1_valid, in2_valid, in3_valid, speed_reverse, therm_valid;
    logic pid_fb1_valid, pid_fb2_valid, pid_ext_valid, config_fault_state;
    logic signed [15:0] speed_ref_rpm, user_prog1_value, user_prog2_value;
    logic signed [15:0] user_prog3_value, therm_value, pid_fb1_value;
    logic signed [15:0] pid_fb2_value, pid_ext_value;
    logic [2:0] user_prog_valid;
    logic [1:0] pid_feedback_mode;
    int errors = 0, n_tests = 0, cyc = 0;
    localparam int TY[7] = '{0, 2, 1, 3, 0, 0, 0};
    localparam int OF[7] = '{0, 0, 0, 0, 100, 0, -1000};
    localparam int GN[7] = '{1000, 1000, 1000, 1000, 2000, 9999, 1000};
    localparam int CD[7] = '{1024, 1024, 1638, 1638, 1024, 2048, 0};
    localparam int EX[7] = '{250, 750, 250, 750, 700, 1000, -1000};
    ain_cond #(.TICK_CYCLES(16)) uut (.*);
    adc_model m1 (.clk, .reset_n, .code(c1), .valid(in1_valid), .sample(in1_sample));
    adc_model m2 (.clk, .reset_n, .code(c2), .valid(in2_valid), .sample(in2_sample));
    adc_model m3 (.clk, .reset_n, .code(c3), .valid(in3_valid), .sample(in3_sample));
    // ===
    // shared tasks
    initial begin
        forever #5 clk = ~clk;
    end
    task chk(string nm, logic [31:0] s, e);
        n_tests++;
        if (s !== e) begin
            errors++;
            $display("FAIL %s expected %h seen %h", nm, e, s);
        end
    endtask
    task wr(logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        addr <= a; wr_data <= d; wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task rd(logic [7:0] a, logic [31:0] e);
        @(posedge clk);
        addr <= a; rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 chk("rd_data", rd_data, e);
    endtask
    task tk(int n);
        repeat (n * 16) @(posedge clk);
    endtask
    task stop_test;
        $display("compares %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ===
    // scenarios
    task t_reset;
        rd(8'h20, 32'h5); rd(8'h40, 32'h8); rd(8'h60, 32'h0);
        rd(8'h28, 32'h3E8); rd(8'h08, 32'h708); rd(8'hF0, 32'h0);
    endtask
    task t_filter;
        wr(8'h30, 32'h1);
        tk(3);
        c1 = 12'hFFF;
        tk(5);
        chk("filt5", pid_fb1_value > 200 && pid_fb1_value < 600, 1);
        tk(28);
        chk("filt33", pid_fb1_value > 900, 1);
        wr(8'h30, 32'h0);
    endtask
    task t_norm;
        for (int i = 0; i < 7; i++) begin
            wr(8'h24, TY[i]); wr(8'h2C, OF[i]); wr(8'h28, GN[i]);
            c1 = CD[i];
            tk(3);
            rd(8'h34, EX[i]);
            chk("fb1", 32'(pid_fb1_value), EX[i]);
        end
        wr(8'h24, 32'h0); wr(8'h2C, 32'h0); wr(8'h28, 32'h3E8);
        wr(8'h64, 32'h4); c3 = 12'hA00; tk(2);
        rd(8'h74, 32'hFA); chk("bip", config_fault_state, 0);
        wr(8'h24, 32'h4); tk(1);
        chk("badtype", config_fault_state, 1); rd(8'h34, 32'h0);
        wr(8'h24, 32'h0); wr(8'h64, 32'h0); tk(1);
    endtask
    task t_route;
        c1 = 12'h400; c2 = 12'hC00;
        wr(8'h40, 32'h5); tk(3);
        chk("prio", pid_fb1_value, 250); chk("ext", pid_ext_valid, 0);
        wr(8'h20, 32'h6); tk(3);
        chk("fb2", pid_fb2_value, 250); chk("fb1", pid_fb1_value, 750);
        wr(8'h20, 32'h8); tk(3);
        chk("extv", pid_ext_value, 250);
        wr(8'h20, 32'h3); tk(3);
        chk("upv", user_prog_valid, 3'h1); chk("up1", user_prog1_value, 250);
        wr(8'h20, 32'h4); tk(3);
        chk("thm", therm_valid, 1); chk("thv", therm_value, 250);
        wr(8'h20, 32'h9); tk(3);
        chk("none", {user_prog_valid, therm_valid, pid_ext_valid}, 0);
        wr(8'h14, 32'h2); tk(1);
        chk("mode", pid_feedback_mode, 2'h2);
        wr(8'h20, 32'h5); wr(8'h40, 32'h8);
    endtask
    task t_fault;
        wr(8'h60, 32'h4); tk(1);
        chk("cfg", config_fault_state, 1); chk("ext", pid_ext_valid, 0);
        wr(8'h60, 32'h0); tk(1);
        chk("cfg_clr", config_fault_state, 0);
    endtask
    task t_speed;
        wr(8'h08, 32'h258); wr(8'h0C, 32'h7D0); wr(8'h10, 32'h7D0);
        wr(8'h20, 32'h0); wr(8'h00, 32'h1); c1 = 12'hFFF; tk(4);
        chk("spd", speed_ref_rpm, 600); chk("fwd", speed_reverse, 0);
        wr(8'h2C, 32'hFFFFFC18); c1 = 12'h000; tk(4);
        chk("rev", speed_reverse, 1);
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            stop_test();
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        t_reset(); t_filter(); t_norm(); t_route(); t_fault(); t_speed();
        stop_test();
    end
endmodule

// ### ain_pkg.sv
// shared constants for the analog input conditioning block
package ain_pkg;
    // ===
    // number formats
    localparam int SAMPLE_W = 12;
    localparam int PCT_MAX = 1000;
    localparam int GAIN_MAX = 9999;
    localparam int TC_MAX = 1600;
    localparam int ADC_4MA = 819;
    localparam int ADC_MID = 2048;
    localparam int NORM_UNI_MUL = 16004;
    localparam int NORM_LOOP_MUL = 20005;
    localparam int NORM_SH = 16;
    localparam int BIP_MUL = 125;
    localparam int BIP_SH = 8;
    localparam longint DIV1000_MUL = 8389;
    localparam int DIV1000_SH = 23;
    localparam logic [16:0] FILT_ONE = 17'h10000;
    localparam logic [4:0] DIV_STEPS = 5'h10;
    // ===
    // function and signal codes
    localparam logic [3:0] FN_SPEED = 4'h0;
    localparam logic [3:0] FN_USER = 4'h3;
    localparam logic [3:0] FN_THERM = 4'h4;
    localparam logic [3:0] FN_PID1 = 4'h5;
    localparam logic [3:0] FN_PID2 = 4'h6;
    localparam logic [3:0] FN_EXT = 4'h8;
    localparam logic [2:0] SIG_UNI = 3'h0;
    localparam logic [2:0] SIG_LOOP = 3'h1;
    localparam logic [2:0] SIG_UNI_INV = 3'h2;
    localparam logic [2:0] SIG_LOOP_INV = 3'h3;
    localparam logic [2:0] SIG_BIPOLAR = 3'h4;
    // ===
    // timing
    localparam int CLK_MHZ = 100;
    localparam int TICK_PERIOD_US = 1000;
    localparam int TICK_CYCLES_DEF = TICK_PERIOD_US * CLK_MHZ;
    localparam int TC_UNIT_MS = 10;
    localparam int TC_TICKS = TC_UNIT_MS * 1000 / TICK_PERIOD_US;
    // ===
    // register offsets and reset values
    localparam logic [7:0] REG_REF_SEL = 8'h00;
    localparam logic [7:0] REG_MIN_SPEED = 8'h04;
    localparam logic [7:0] REG_MAX_SPEED = 8'h08;
    localparam logic [7:0] REG_RAMP_ACC = 8'h0C;
    localparam logic [7:0] REG_RAMP_DEC = 8'h10;
    localparam logic [7:0] REG_PID_MODE = 8'h14;
    localparam logic [7:0] REG_STATUS = 8'h18;
    localparam logic [4:0] CH_FUNC = 5'h00;
    localparam logic [4:0] CH_TYPE = 5'h04;
    localparam logic [4:0] CH_GAIN = 5'h08;
    localparam logic [4:0] CH_OFFSET = 5'h0C;
    localparam logic [4:0] CH_FILT = 5'h10;
    localparam logic [4:0] CH_VALUE = 5'h14;
    localparam logic [13:0] RST_GAIN = 14'h03E8;
    localparam logic [2:0][3:0] RST_FUNC = {4'h0, 4'h8, 4'h5};
    localparam logic [15:0] RST_MIN_SPEED = 16'h0000;
    localparam logic [15:0] RST_MAX_SPEED = 16'h0708;
    localparam logic [15:0] RST_RAMP_STEP = 16'h0001;
endpackage

// ### chan_cond.sv
// one analog channel: normalise, offset, gain, invert and low-pass filter
`timescale 1ns/1ps
module chan_cond #(
    parameter bit BIPOLAR_OK = 1'b0
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic sample_valid,
    input wire logic [ain_pkg::SAMPLE_W-1:0] sample,
    input wire logic [2:0] signal_type,
    input wire logic signed [15:0] offset,
    input wire logic [13:0] gain,
    input wire logic [10:0] filter_tc,
    input wire logic tick,
    output logic signed [15:0] cond_value,
    output logic signed [15:0] filt_value,
    output logic type_bad
);
    import ain_pkg::*;

    typedef struct packed {
        logic signed [15:0] norm;
        logic norm_v;
        logic signed [15:0] cond;
        logic signed [47:0] acc;
        logic [16:0] coef;
        logic [16:0] quo;
        logic [16:0] rem;
        logic [4:0] step;
        logic bad;
    } chan_state_t;

    chan_state_t q, n;

    // ===
    // datapath
    always_comb begin
        int u;
        int p;
        longint m;
        longint diff;
        logic [17:0] dvs;
        logic [17:0] trial;
        logic [16:0] nq;
        u = int'(sample);
        p = 0;
        m = 0;
        diff = 0;
        nq = '0;
        n = q;
        n.bad = (signal_type > SIG_BIPOLAR)
            || (signal_type == SIG_BIPOLAR && !BIPOLAR_OK); // [R9]
        case (signal_type)
            SIG_LOOP, SIG_LOOP_INV: begin
                // live zero removed first, span is the remaining 16 mA
                p = (u > ADC_4MA) ?
                    ((u - ADC_4MA) * NORM_LOOP_MUL) >>> NORM_SH : 0; // [R11]
            end
            SIG_BIPOLAR: p = ((u - ADC_MID) * BIP_MUL) >>> BIP_SH; // [R9]
            default: p = (u * NORM_UNI_MUL) >>> NORM_SH; // [R11]
        endcase
        n.norm_v = sample_valid && !n.bad; // [R8]
        if (sample_valid) begin
            n.norm = 16'(p);
        end
        if (q.norm_v) begin
            m = (longint'(int'(q.norm) + int'(offset)) * longint'(gain)
                * DIV1000_MUL) >>> DIV1000_SH; // [R11] [R16]
            if (m > PCT_MAX) m = PCT_MAX; // [R16]
            if (m < -PCT_MAX) m = -PCT_MAX;
            if (signal_type == SIG_UNI_INV || signal_type == SIG_LOOP_INV) begin
                m = PCT_MAX - m; // [R10]
                if (m > PCT_MAX) m = PCT_MAX;
            end
            n.cond = 16'(m);
        end
        if (n.bad) begin
            n.cond = '0;
        end
        // coefficient = tick / (tc + tick), refreshed by a serial divider
        dvs = 18'(int'(filter_tc) * TC_TICKS + 1); // [R17]
        trial = {q.rem, FILT_ONE[q.step]};
        if (trial >= dvs) begin
            n.rem = 17'(trial - dvs);
            nq = {q.quo[15:0], 1'b1};
        end else begin
            n.rem = 17'(trial);
            nq = {q.quo[15:0], 1'b0};
        end
        n.quo = nq;
        if (q.step == '0) begin
            n.coef = nq; // [R17]
            n.step = DIV_STEPS;
            n.rem = '0;
            n.quo = '0;
        end else begin
            n.step = q.step - 5'h01;
        end
        // first-order lag: settles to a step in about three time constants
        if (tick) begin
            diff = (longint'(q.cond) <<< 16) - longint'(q.acc);
            n.acc = 48'(longint'(q.acc)
                + ((diff * longint'(q.coef)) >>> 16)); // [R13] [R14]
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            q <= '{norm: '0, norm_v: 1'b0, cond: '0, acc: '0, coef: FILT_ONE,
                   quo: '0, rem: '0, step: DIV_STEPS, bad: 1'b0};
        end else begin
            q <= n;
        end
    end

    assign cond_value = q.cond;
    assign filt_value = q.acc[31:16];
    assign type_bad = q.bad;
endmodule

// ### speed_ramp.sv
// acceleration and deceleration ramp on the speed reference
`timescale 1ns/1ps
module speed_ramp (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic tick,
    input wire logic signed [15:0] target,
    input wire logic [15:0] acc_step,
    input wire logic [15:0] dec_step,
    output logic signed [15:0] speed
);
    typedef struct packed {
        logic signed [15:0] speed;
    } ramp_state_t;

    ramp_state_t q, n;

    // ===
    // ramp
    always_comb begin
        int s;
        int t;
        int up;
        int dn;
        s = int'(q.speed);
        t = int'(target);
        // moving away from zero uses the acceleration rate
        up = (s >= 0) ? int'(acc_step) : int'(dec_step);
        dn = (s <= 0) ? int'(acc_step) : int'(dec_step);
        n = q;
        if (tick) begin
            if (s < t) begin
                n.speed = 16'((s + up > t) ? t : s + up); // [R2]
            end else if (s > t) begin
                n.speed = 16'((s - dn < t) ? t : s - dn); // [R2]
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            q <= '{speed: '0};
        end else begin
            q <= n;
        end
    end

    assign speed = q.speed;
endmodule
